// >>> common/fmsp_consts.svh
// Opcodes, timing figures and widths of the flash mode and suspend controller
// Overview of operation
// RULE1: Enter-quad code switches all later commands to quad
// RULE2: Exit-quad code framed by select restores single-bit
// RULE3: Exit-quad taken only as two-clock quad cycle
// RULE4: Suspend and resume accepted in both modes
// RULE5: Program and erase suspend flags are visible
// RULE6: Ready 100us after suspend; resume-suspend spacing 400us
// RULE7: Suspend clears write latch; restricted command set
// RULE8: Host frames one suspend cycle with select
// RULE9: Erase suspend sets flag, refuses commands until ready; code still accepts status reads (05h) in FMSP_SWAIT
// RULE10: Program suspend sets flag, refuses commands until ready; code still accepts status reads (05h) in FMSP_SWAIT
// RULE11: Framed resume restarts operation, clears its flag
// RULE12: Quad cycle is two nibbles, high first
// RULE13: Suspended operation never runs longer in total
// RULE14: Suspended: normal, fast, multi-bit reads, status, function
// RULE15: Suspended: identity, unique, discovery, parameter, nop, info
// RULE16: Suspended: reset only right after reset-enable
// RULE17: Sleep entered on select rise after latched code
// RULE18: Asleep only the wake code is recognised
// RULE19: No command accepted during the wake time
// RULE20: Wake code ignored while operation in progress
// RULE21: In-progress bit high while program or erase runs
// RULE22: Write-enable sets latch needed before any write
// RULE23: Suspended: other commands ignored without any effect
`ifndef FMSP_CONSTS_SVH
`define FMSP_CONSTS_SVH

`define FMSP_CLK_NS          10
`define FMSP_SUS_READY_NS    100000
`define FMSP_RSM_GUARD_NS    400000
`define FMSP_SLEEP_ENTRY_NS  3000
`define FMSP_WAKE_NS         5000
`define FMSP_SLEEP_CYC       (`FMSP_SLEEP_ENTRY_NS / `FMSP_CLK_NS)
`define FMSP_WAKE_CYC        ((`FMSP_WAKE_NS + `FMSP_CLK_NS - 1) / `FMSP_CLK_NS)

`define FMSP_SPI_OP_CLKS     8'h08
`define FMSP_QUAD_OP_CLKS    8'h02

`define FMSP_OP_ENTER_QUAD   8'h35
`define FMSP_OP_EXIT_QUAD    8'hf5
`define FMSP_OP_SUSPEND_A    8'h75
`define FMSP_OP_SUSPEND_B    8'hb0
`define FMSP_OP_RESUME_A     8'h7a
`define FMSP_OP_RESUME_B     8'h30
`define FMSP_OP_WRITE_ENABLE_CMD         8'h06
`define FMSP_OP_WRDI         8'h04
`define FMSP_OP_STATUS       8'h05
`define FMSP_OP_FUNC_READ    8'h48
`define FMSP_OP_SLEEP        8'hb9
`define FMSP_OP_WAKE         8'hab
`define FMSP_OP_RST_EN       8'h66
`define FMSP_OP_RST          8'h99
`define FMSP_OP_NOP          8'h00

`endif

// >>> common/fmsp_pkg.sv
// Types shared by the flash mode and suspend controller
package fmsp_pkg;
    typedef enum logic [6:0] {
        FMSP_IDLE  = 7'h01,
        FMSP_BUSY  = 7'h02,
        FMSP_SWAIT = 7'h04,
        FMSP_SUSP  = 7'h08,
        FMSP_ENTRY = 7'h10,
        FMSP_SLEEP = 7'h20,
        FMSP_WAKE  = 7'h40
    } fmsp_state_t;

    typedef logic [7:0] fmsp_op_t;
endpackage : fmsp_pkg

// >>> common/fmsp_link_if.sv
// Carrier between the serial receiver and the mode controller
`timescale 1ns/1ps
interface fmsp_link_if;
    import fmsp_pkg::*;
    logic     quad;
    fmsp_op_t op;
    logic     op_valid;
    logic     frame_end;
    logic [7:0] clocks;

    modport rx  (input quad, output op, op_valid, frame_end, clocks);
    modport ctl (output quad, input op, op_valid, frame_end, clocks);
endinterface : fmsp_link_if

// >>> verilog/fmsp_rx.sv
// Pin synchroniser and opcode shifter for single-bit and quad frames
`timescale 1ns/1ps
`include "fmsp_consts.svh"
module fmsp_rx
    import fmsp_pkg::*;
(
    input wire logic   ref_clk,
    input wire logic   rst,
    input wire logic   sclk_pin,
    input wire logic   cs_n_pin,
    input wire logic [3:0] sio_pin,
    fmsp_link_if.rx    lk
);
    // ****************************************
    // Synchronisers
    // ****************************************
    logic [5:0] meta;
    logic [5:0] sync;
    logic       sclk_d;
    logic       cs_d;
    logic [7:0] shift;
    logic [7:0] cnt;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            meta   <= 6'h02;
            sync   <= 6'h02;
            sclk_d <= 1'b0;
            cs_d   <= 1'b1;
        end
        else
        begin
            meta   <= {sio_pin, cs_n_pin, sclk_pin};
            sync   <= meta;
            sclk_d <= sync[0];
            cs_d   <= sync[1];
        end
    end

    // ****************************************
    // Shifter
    // ****************************************
    wire       s_rise  = sync[0] & ~sclk_d & ~sync[1];
    wire       cs_rise = sync[1] & ~cs_d;
    // High nibble arrives first in quad mode
    wire [7:0] next_shift = lk.quad ? {shift[3:0], sync[5:2]}
                                    : {shift[6:0], sync[2]}; // see RULE12
    wire       op_last = lk.quad ? (cnt == 8'h01) : (cnt == 8'h07);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            shift        <= 8'h00;
            cnt          <= 8'h00;
            lk.op        <= 8'h00;
            lk.op_valid  <= 1'b0;
            lk.frame_end <= 1'b0;
            lk.clocks    <= 8'h00;
        end
        else
        begin
            lk.op_valid  <= s_rise & op_last;
            lk.frame_end <= cs_rise;
            if (s_rise)
            begin
                shift <= next_shift;
                cnt   <= (cnt == 8'hff) ? cnt : cnt + 8'h01;
            end
            if (s_rise & op_last)
                lk.op <= next_shift;
            if (cs_rise)
                lk.clocks <= cnt;
            if (sync[1])
                cnt <= 8'h00;
        end
    end
endmodule : fmsp_rx

// >>> verilog/fmsp_ctl.sv
// Command-mode, suspend/resume and deep sleep control of a serial flash
`timescale 1ns/1ps
`include "fmsp_consts.svh"
module fmsp_ctl
    import fmsp_pkg::*;
#(
    parameter int unsigned SUS_LAT_CYC   = `FMSP_SUS_READY_NS / `FMSP_CLK_NS,
    parameter int unsigned RSM_GUARD_CYC = `FMSP_RSM_GUARD_NS / `FMSP_CLK_NS
)
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        sclk_pin,
    input  wire logic        cs_n_pin,
    input  wire logic [3:0]  sio_pin,
    input  wire logic        op_start,
    input  wire logic        op_erase,
    input  wire logic [23:0] op_len,
    output logic             quad_command_mode,
    output logic             write_enable_latch,
    output logic             in_progress_bit,
    output logic             program_suspended_flag,
    output logic             erase_suspended_flag,
    output logic             deep_sleep,
    output logic             op_running,
    output logic             cmd_accept,
    output logic [7:0]       cmd_code,
    output logic             sw_reset
);
    // ****************************************
    // Receiver
    // ****************************************
    fmsp_link_if lk();

    fmsp_rx u_rx (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .sclk_pin (sclk_pin),
        .cs_n_pin (cs_n_pin),
        .sio_pin  (sio_pin),
        .lk       (lk.rx)
    );

    assign lk.quad = quad_command_mode;

    // ****************************************
    // Opcode classes
    // ****************************************
    function automatic logic read_class(input fmsp_op_t op);
        case (op)
            8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h0d, 8'hbd, 8'hed,
            8'h05, 8'h48: read_class = 1'b1;
            8'hab, 8'h9f, 8'h90, 8'haf, 8'h4b, 8'h5a, 8'hc0,
            8'h68: read_class = 1'b1;
            default: read_class = 1'b0;
        endcase
    endfunction : read_class

    fmsp_state_t st;
    fmsp_state_t next_st;
    logic [15:0] tmr;
    logic [15:0] guard;
    logic [23:0] left;
    logic        erase_op;
    logic        rst_armed;

    wire st_idle  = (st == FMSP_IDLE);
    wire st_busy  = (st == FMSP_BUSY);
    wire st_swait = (st == FMSP_SWAIT);
    wire st_susp  = (st == FMSP_SUSP);
    wire st_sleep = (st == FMSP_SLEEP);
    wire st_wake  = (st == FMSP_WAKE);

    // One-byte commands only count when the frame held exactly one opcode
    wire fr_len_ok = quad_command_mode ? (lk.clocks == `FMSP_QUAD_OP_CLKS)
                                       : (lk.clocks == `FMSP_SPI_OP_CLKS);
    wire fr_ok     = lk.frame_end & fr_len_ok;
    wire [7:0] fop = lk.op;

    wire is_susp   = (fop == `FMSP_OP_SUSPEND_A) | (fop == `FMSP_OP_SUSPEND_B);
    wire is_resume = (fop == `FMSP_OP_RESUME_A) | (fop == `FMSP_OP_RESUME_B);

    wire f_quad_on  = fr_ok & st_idle & ~quad_command_mode
                    & (fop == `FMSP_OP_ENTER_QUAD); // see RULE1
    wire f_quad_off = fr_ok & st_idle & quad_command_mode
                    & (fop == `FMSP_OP_EXIT_QUAD); // see RULE2 see RULE3
    wire f_write_enable_cmd     = fr_ok & st_idle & (fop == `FMSP_OP_WRITE_ENABLE_CMD); // see RULE22
    wire f_wrdi     = fr_ok & st_idle & (fop == `FMSP_OP_WRDI);
    wire f_sleep    = fr_ok & st_idle & (fop == `FMSP_OP_SLEEP); // see RULE17
    // A running program or erase must not be disturbed by the wake code
    wire f_wake     = fr_ok & st_sleep & (fop == `FMSP_OP_WAKE); // see RULE18 see RULE20
    wire guard_ok   = (guard == 16'h0000);
    wire f_susp     = fr_ok & st_busy & ~op_fin & is_susp & guard_ok; // see RULE4 see RULE6
    wire f_resume   = fr_ok & st_susp & is_resume; // see RULE4 see RULE11
    wire f_rst_en   = fr_ok & (st_idle | st_susp) & (fop == `FMSP_OP_RST_EN);
    wire f_rst      = fr_ok & (st_idle | st_susp) & rst_armed
                    & (fop == `FMSP_OP_RST); // see RULE16
    wire f_nop      = fr_ok & (st_idle | st_susp) & (fop == `FMSP_OP_NOP);

    // Reads start on the opcode itself; status stays open while busy
    wire rd_ok = lk.op_valid & ((st_idle | st_susp) & read_class(fop)
               | (st_busy | st_swait) & (fop == `FMSP_OP_STATUS)); // see RULE14 see RULE15

    wire start_ok = op_start & st_idle & write_enable_latch; // see RULE22
    wire op_fin   = st_busy & (left <= 24'h000001);
    wire tmr_done = (tmr == 16'h0000);

    // Anything outside the accepted set falls through with no effect
    wire acc_now = rd_ok | f_quad_on | f_quad_off | f_write_enable_cmd | f_wrdi | f_sleep
                 | f_wake | f_susp | f_resume | f_rst_en | f_rst | f_nop; // see RULE23

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb
    begin
        next_st = st;
        case (st)
            FMSP_IDLE:
                if (start_ok)
                    next_st = FMSP_BUSY;
                else if (f_sleep)
                    next_st = FMSP_ENTRY;
            FMSP_BUSY:
                if (op_fin)
                    next_st = FMSP_IDLE;
                else if (f_susp)
                    next_st = FMSP_SWAIT; // see RULE9 see RULE10
            FMSP_SWAIT:
                if (tmr_done)
                    next_st = FMSP_SUSP; // see RULE6
            FMSP_SUSP:
                if (f_resume)
                    next_st = FMSP_BUSY;
            FMSP_ENTRY:
                if (tmr_done)
                    next_st = FMSP_SLEEP; // see RULE17
            FMSP_SLEEP:
                if (f_wake)
                    next_st = FMSP_WAKE;
            FMSP_WAKE:
                if (tmr_done)
                    next_st = FMSP_IDLE; // see RULE19
            default:
                next_st = FMSP_IDLE;
        endcase
    end

    wire [15:0] sus_load   = 16'(SUS_LAT_CYC - 1);
    wire [15:0] sleep_load = 16'(`FMSP_SLEEP_CYC - 1);
    wire [15:0] wake_load  = 16'(`FMSP_WAKE_CYC - 1);
    wire [15:0] tmr_load   = (next_st == FMSP_SWAIT) ? sus_load
                           : (next_st == FMSP_ENTRY) ? sleep_load : wake_load;
    wire        st_change  = (next_st != st);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            st <= FMSP_IDLE;
        else
            st <= next_st;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            tmr <= 16'h0000;
        else if (st_change)
            tmr <= tmr_load;
        else if (~tmr_done)
            tmr <= tmr - 16'h0001;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            guard <= 16'h0000;
        else if (f_resume)
            guard <= 16'(RSM_GUARD_CYC - 1);
        else if (~guard_ok)
            guard <= guard - 16'h0001;
    end

    // Remaining time only runs while busy, so suspension never adds to it
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            left     <= 24'h000000;
            erase_op <= 1'b0;
        end
        else if (start_ok)
        begin
            left     <= op_len;
            erase_op <= op_erase;
        end
        else if (st_busy & ~op_fin)
            left <= left - 24'h000001; // see RULE13
    end

    // ****************************************
    // Flags and outputs
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            quad_command_mode <= 1'b0;
        else if (f_quad_on)
            quad_command_mode <= 1'b1; // see RULE1
        else if (f_quad_off)
            quad_command_mode <= 1'b0; // see RULE2
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst | op_fin | f_wrdi | f_susp | f_rst)
            write_enable_latch <= 1'b0; // see RULE7
        else if (f_write_enable_cmd)
            write_enable_latch <= 1'b1; // see RULE22
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            program_suspended_flag <= 1'b0;
            erase_suspended_flag   <= 1'b0;
        end
        else if (f_susp)
        begin
            program_suspended_flag <= ~erase_op; // see RULE5 see RULE10
            erase_suspended_flag   <= erase_op; // see RULE5 see RULE9
        end
        else if (f_resume)
        begin
            program_suspended_flag <= 1'b0; // see RULE11
            erase_suspended_flag   <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rst_armed <= 1'b0;
        else if (lk.frame_end)
            rst_armed <= f_rst_en;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            in_progress_bit <= 1'b0;
            deep_sleep      <= 1'b0;
            op_running      <= 1'b0;
            cmd_accept      <= 1'b0;
            cmd_code        <= 8'h00;
            sw_reset        <= 1'b0;
        end
        else
        begin
            in_progress_bit <= (next_st == FMSP_BUSY) | (next_st == FMSP_SWAIT); // see RULE21
            deep_sleep      <= (next_st == FMSP_SLEEP) | (next_st == FMSP_WAKE);
            op_running      <= (next_st == FMSP_BUSY);
            cmd_accept      <= acc_now;
            cmd_code        <= acc_now ? fop : cmd_code;
            sw_reset        <= f_rst;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_quad_enter;
        @(posedge ref_clk) disable iff (rst)
        $rose(quad_command_mode) |-> $past(fop) == `FMSP_OP_ENTER_QUAD;
    endproperty
    a_quad_enter: assert property (p_quad_enter) else $error("quad entered without code"); // see RULE1

    property p_quad_exit;
        @(posedge ref_clk) disable iff (rst)
        $fell(quad_command_mode) |-> $past(lk.clocks) == `FMSP_QUAD_OP_CLKS
                                     && $past(fop) == `FMSP_OP_EXIT_QUAD;
    endproperty
    a_quad_exit: assert property (p_quad_exit) else $error("quad left wrongly"); // see RULE3

    property p_susp_wel;
        @(posedge ref_clk) disable iff (rst)
        f_susp |=> !write_enable_latch && (program_suspended_flag ^ erase_suspended_flag)
                   && in_progress_bit && st_swait;
    endproperty
    a_susp_wel: assert property (p_susp_wel) else $error("suspend left latch set"); // see RULE7

    logic [15:0] sus_age;
    always_ff @(posedge ref_clk)
        sus_age <= (rst | ~st_swait) ? 16'h0000 : sus_age + 16'h0001;

    property p_susp_ready;
        @(posedge ref_clk) disable iff (rst)
        (st_swait && sus_age == 16'(SUS_LAT_CYC - 1)) |=> st_susp && !in_progress_bit;
    endproperty
    a_susp_ready: assert property (p_susp_ready) else $error("suspend latency wrong"); // see RULE6

    property p_resume;
        @(posedge ref_clk) disable iff (rst)
        f_resume |=> !program_suspended_flag && !erase_suspended_flag && op_running;
    endproperty
    a_resume: assert property (p_resume) else $error("resume flag not cleared"); // see RULE11

    property p_hold_left;
        @(posedge ref_clk) disable iff (rst)
        st_susp |=> $stable(left);
    endproperty
    a_hold_left: assert property (p_hold_left) else $error("time ran while suspended"); // see RULE13

    property p_sleep_quiet;
        @(posedge ref_clk) disable iff (rst)
        (st_sleep && !f_wake) |=> !cmd_accept && (st_sleep || st_wake);
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("command taken asleep"); // see RULE18

    property p_wake_quiet;
        @(posedge ref_clk) disable iff (rst)
        st_wake |=> !cmd_accept;
    endproperty
    a_wake_quiet: assert property (p_wake_quiet) else $error("command during wake"); // see RULE19

    property p_wip;
        @(posedge ref_clk) disable iff (rst)
        start_ok |=> in_progress_bit && op_running;
    endproperty
    a_wip: assert property (p_wip) else $error("progress bit not set"); // see RULE21

    property p_susp_ignore;
        @(posedge ref_clk) disable iff (rst)
        (st_susp && fr_ok && !is_resume && fop != `FMSP_OP_RST_EN && fop != `FMSP_OP_RST
         && fop != `FMSP_OP_NOP) |=> $stable(write_enable_latch) && st_susp;
    endproperty
    a_susp_ignore: assert property (p_susp_ignore) else $error("suspended state disturbed"); // see RULE23

    c_erase_susp: cover property (@(posedge ref_clk) disable iff (rst) f_susp && erase_op);
    c_prog_resume: cover property (@(posedge ref_clk) disable iff (rst) f_resume && !erase_op);
    c_wake: cover property (@(posedge ref_clk) disable iff (rst) st_wake ##1 st_idle);
    c_quad_exit: cover property (@(posedge ref_clk) disable iff (rst) f_quad_off);
endmodule : fmsp_ctl

// >>> verification/fmsp_host_model.sv
// Host-side serial flash controller model driving select, clock and data
`timescale 1ns/1ps
module fmsp_host_model
(
    output logic       sclk_pin,
    output logic       cs_n_pin,
    output logic [3:0] sio_pin
);
    // ************
    // Frame driver
    // ************
    initial
    begin
        sclk_pin = 1'b0;
        cs_n_pin = 1'b1;
        sio_pin  = 4'ha;
    end

    // One command cycle framed by select; clock parked low outside frames
    task automatic send(input logic [7:0] op, input int nclk, input bit quad);
        int i;
        cs_n_pin = 1'b0;
        for (i = 0; i < nclk; i++)
        begin
            if (quad)
                sio_pin = (i % 2 == 0) ? op[7:4] : op[3:0];
            else
                sio_pin = {~sio_pin[3:1], op[7 - (i % 8)]};
            #62.5 sclk_pin = 1'b1;
            #62.5 sclk_pin = 1'b0;
        end
        #62.5 cs_n_pin = 1'b1;
        // Released lines must not look held, so show the inverse
        sio_pin = ~sio_pin;
        #250;
    endtask : send
endmodule : fmsp_host_model

// >>> verification/flash_mode_suspend_powerdown_ctl_tb_top.sv
// Self-checking bench of the flash mode, suspend and sleep controller
`timescale 1ns/1ps
module flash_mode_suspend_powerdown_ctl_tb_top;
    logic        ref_clk;
    logic        rst;
    logic        sclk_pin;
    logic        cs_n_pin;
    logic [3:0]  sio_pin;
    logic        op_start;
    logic        op_erase;
    logic [23:0] op_len;
    logic        quad_command_mode;
    logic        write_enable_latch;
    logic        in_progress_bit;
    logic        program_suspended_flag;
    logic        erase_suspended_flag;
    logic        deep_sleep;
    logic        op_running;
    logic        cmd_accept;
    logic [7:0]  cmd_code;
    logic        sw_reset;
    int          errors;
    int          total_checks;
    int          acc_cnt;
    int          rst_cnt;
    int          run_cnt;
    int          a0;
    int          len;
    int          i;
    int          m_quad;
    int          m_wel;
    int          m_program_suspended_flag;
    int          m_erase_suspended_flag;
    int          m_sleep;
    logic [7:0]  reads [$] = '{8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h0d, 8'hbd, 8'hed,
                                8'h05, 8'h48, 8'hab, 8'h9f, 8'h90, 8'haf, 8'h4b, 8'h5a,
                                8'hc0, 8'h68};

    // Latency shortened so suspend windows end within the bench's 300-cycle waits
    fmsp_ctl #(
        .SUS_LAT_CYC   (300),
        .RSM_GUARD_CYC (500)
    ) fmsp_ctl_i (
        .ref_clk                (ref_clk),
        .rst                    (rst),
        .sclk_pin               (sclk_pin),
        .cs_n_pin               (cs_n_pin),
        .sio_pin                (sio_pin),
        .op_start               (op_start),
        .op_erase               (op_erase),
        .op_len                 (op_len),
        .quad_command_mode      (quad_command_mode),
        .write_enable_latch     (write_enable_latch),
        .in_progress_bit        (in_progress_bit),
        .program_suspended_flag (program_suspended_flag),
        .erase_suspended_flag   (erase_suspended_flag),
        .deep_sleep             (deep_sleep),
        .op_running             (op_running),
        .cmd_accept             (cmd_accept),
        .cmd_code               (cmd_code),
        .sw_reset               (sw_reset)
    );

    fmsp_host_model fmsp_host_model_i (
        .sclk_pin (sclk_pin),
        .cs_n_pin (cs_n_pin),
        .sio_pin  (sio_pin)
    );

    // ***********************
    // Clock and event counters
    // ***********************
    always #5 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        if (cmd_accept === 1'b1)
            acc_cnt <= acc_cnt + 1;
        if (sw_reset === 1'b1)
            rst_cnt <= rst_cnt + 1;
        if (op_start === 1'b1)
            run_cnt <= 0;
        else if (op_running === 1'b1)
            run_cnt <= run_cnt + 1;
    end

    // *****
    // Tasks
    // *****
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk

    task automatic check_state();
        chk("quad", quad_command_mode, m_quad);
        chk("wel", write_enable_latch, m_wel);
        chk("program_suspended_flag", program_suspended_flag, m_program_suspended_flag);
        chk("erase_suspended_flag", erase_suspended_flag, m_erase_suspended_flag);
        chk("sleep", deep_sleep, m_sleep);
    endtask : check_state

    task automatic close_out();
        $display("Checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    // Zero clock count means the normal cycle length of the current mode
    task automatic cmd(input logic [7:0] op, input int nclk);
        int n;
        n = (nclk != 0) ? nclk : ((m_quad != 0) ? 2 : 8);
        @(negedge ref_clk);
        fmsp_host_model_i.send(op, n, m_quad != 0);
        repeat (10) @(negedge ref_clk);
    endtask : cmd

    task automatic wait_for(input bit sel, input logic v, input int bound);
        int n;
        n = 0;
        while (((sel ? deep_sleep : in_progress_bit) !== v) && n < bound)
        begin
            @(negedge ref_clk);
            n++;
        end
        if ((sel ? deep_sleep : in_progress_bit) !== v)
        begin
            errors++;
            $display("BAD wait expected %0h seen timeout", v);
            close_out();
        end
    endtask : wait_for

    task automatic start_op(input logic erase, input int n);
        @(negedge ref_clk);
        op_erase = erase;
        op_len   = n[23:0];
        op_start = 1'b1;
        @(negedge ref_clk);
        op_start = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask : start_op

    // *************
    // Main sequence
    // *************
    initial
    begin
        ref_clk = 1'b0;
        rst = 1'b1;
        op_start = 1'b0;
        op_erase = 1'b0;
        op_len = 24'h000001;
        {errors, total_checks, acc_cnt, rst_cnt, run_cnt} = '0;
        {m_quad, m_wel, m_program_suspended_flag, m_erase_suspended_flag, m_sleep} = '0;
        void'($urandom(32'hdd7c584c));
        len = 3000 + $urandom_range(0, 1000);
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        check_state();
        chk("code", cmd_code, 8'h00);
        cmd(8'h06, 0);
        m_wel = 1;
        check_state();
        cmd(8'h35, 0);
        m_quad = 1;
        check_state();
        cmd(8'h04, 0);
        m_wel = 0;
        chk("code", cmd_code, 8'h04);
        check_state();
        cmd(8'hf5, 8);
        check_state();
        cmd(8'hf5, 0);
        m_quad = 0;
        check_state();
        cmd(8'h06, 0);
        m_wel = 1;
        start_op(1'b0, len);
        chk("busy", in_progress_bit, 1'b1);
        a0 = acc_cnt;
        cmd(8'hab, 0);
        check_state();
        chk("accept", acc_cnt - a0, 0);
        chk("busy", in_progress_bit, 1'b1);
        repeat (600) @(negedge ref_clk);
        cmd(8'h75, 0);
        m_program_suspended_flag = 1;
        m_wel = 0;
        check_state();
        a0 = acc_cnt;
        cmd(8'h03, 0);
        chk("accept", acc_cnt - a0, 0);
        wait_for(1'b0, 1'b0, 300);
        a0 = acc_cnt;
        cmd(8'h06, 0);
        chk("accept", acc_cnt - a0, 0);
        check_state();
        for (i = 0; i < reads.size(); i++)
        begin
            a0 = acc_cnt;
            cmd(reads[i], 0);
            chk("accept", acc_cnt - a0, 1);
            chk("code", cmd_code, reads[i]);
        end
        a0 = rst_cnt;
        cmd(8'h99, 0);
        chk("swreset", rst_cnt - a0, 0);
        cmd(8'h66, 0);
        cmd(8'h99, 0);
        chk("swreset", rst_cnt - a0, 1);
        cmd(8'h7a, 0);
        m_program_suspended_flag = 0;
        check_state();
        chk("busy", in_progress_bit, 1'b1);
        cmd(8'h75, 0);
        check_state();
        wait_for(1'b0, 1'b0, len + 100);
        chk("time", run_cnt <= len, 1'b1);
        cmd(8'h35, 0);
        m_quad = 1;
        cmd(8'h06, 0);
        m_wel = 1;
        start_op(1'b1, len);
        repeat (600) @(negedge ref_clk);
        cmd(8'hb0, 0);
        m_erase_suspended_flag = 1;
        m_wel = 0;
        check_state();
        wait_for(1'b0, 1'b0, 300);
        cmd(8'h30, 0);
        m_erase_suspended_flag = 0;
        check_state();
        wait_for(1'b0, 1'b0, len + 100);
        chk("time", run_cnt <= len, 1'b1);
        cmd(8'hf5, 0);
        m_quad = 0;
        cmd(8'hb9, 0);
        wait_for(1'b1, 1'b1, 400);
        m_sleep = 1;
        a0 = acc_cnt;
        cmd(8'h05, 0);
        cmd(8'h06, 0);
        chk("accept", acc_cnt - a0, 0);
        check_state();
        cmd(8'hab, 0);
        chk("sleep", deep_sleep, 1'b1);
        wait_for(1'b1, 1'b0, 600);
        m_sleep = 0;
        cmd(8'h06, 0);
        m_wel = 1;
        check_state();
        close_out();
    end
endmodule : flash_mode_suspend_powerdown_ctl_tb_top
